//--- rtl/xbs_pkg.sv
// Package: register map, field layout and signal order of the crossbar peripheral select
package xbs_pkg;
	localparam logic [7:0] SFR_PAGE = 8'h0f;
	localparam logic [7:0] SELA_ADDR = 8'he1;
	localparam logic [7:0] SELB_ADDR = 8'he2;
	localparam logic [7:0] SELA_RESET = 8'h00;
	localparam logic [7:0] SELB_RESET = 8'h00;
	// crossbar_select_a fields
	localparam int A_CMP1_ASYNC = 7;
	localparam int A_CMP1 = 6;
	localparam int A_CMP0_ASYNC = 5;
	localparam int A_CMP0 = 4;
	localparam int A_TWOWIRE = 3;
	localparam int A_SPI = 2;
	localparam int A_CAN = 1;
	localparam int A_UART = 0;
	// crossbar_select_b fields
	localparam int B_TIMER1 = 7;
	localparam int B_TIMER0 = 6;
	localparam int B_ECI = 5;
	localparam int B_LINES_HI = 4;
	localparam int B_LINES_LO = 2;
	localparam int B_SYSCLK = 1;
	localparam logic [2:0] LINES_RSVD = 3'h7;
	// Assignable signals, listed in priority order
	localparam int S_SPI_SCK = 0;
	localparam int S_SPI_MISO = 1;
	localparam int S_SPI_MOSI = 2;
	localparam int S_SPI_NSS = 3;
	localparam int S_TW_SDA = 4;
	localparam int S_TW_SCL = 5;
	localparam int S_CMP0 = 6;
	localparam int S_CMP0_ASYNC = 7;
	localparam int S_CMP1 = 8;
	localparam int S_CMP1_ASYNC = 9;
	localparam int S_SYSCLK = 10;
	localparam int S_LINE0 = 11;
	localparam int S_ECI = 17;
	localparam int S_TIMER0 = 18;
	localparam int S_TIMER1 = 19;
	localparam int NSIG = 20;
	localparam int SIG_IW = 5;
	localparam int NLINES = 6;
	// Fixed pin positions on port 0
	localparam int PIN_UART_TX = 4;
	localparam int PIN_UART_RX = 5;
	localparam int PIN_CAN_TX = 6;
	localparam int PIN_CAN_RX = 7;
endpackage : xbs_pkg

//--- rtl/xbs_prio_dec.sv
// Priority decoder: hands requested signals to free pins in order
`timescale 1ns/100ps
module xbs_prio_dec #(
	parameter int NSIG = 20,
	parameter int NPINS = 8,
	parameter int IW = 5
) (
	input wire logic [NSIG-1:0] req,
	input wire logic [NPINS-1:0] blocked,
	output logic [NPINS*IW-1:0] pin_sel,
	output logic [NPINS-1:0] pin_hit
);
	always_comb
	begin
		int cur;
		int sel;
		logic found;
		cur = 0;
		sel = 0;
		found = 1'b0;
		pin_sel = '0;
		pin_hit = '0;
		for (int p = 0; p < NPINS; p++)
		begin
			// Skipped or fixed pins are passed over; free pins left without a signal stay GPIO
			if (!blocked[p])
			begin
				found = 1'b0;
				sel = 0;
				for (int s = 0; s < NSIG; s++)
				begin
					if (!found && s >= cur && req[s])
					begin
						found = 1'b1;
						sel = s;
					end
				end
				if (found)
				begin
					pin_hit[p] = 1'b1;
					pin_sel[p*IW +: IW] = IW'(sel);
					cur = sel + 1;
				end
			end
		end
	end
endmodule : xbs_prio_dec

//--- rtl/xbs_crossbar_sel.sv
// Crossbar peripheral select: select registers, pin assignment and pin muxing
//
// Function
// - Select A bit 7 routes async comparator one
// - Select A bit 6 routes comparator one
// - Select A bit 5 routes async comparator zero
// - Select A bit 4 routes comparator zero
// - Select A bit 3 routes both two-wire lines
// - Select A bit 2 routes SPI, three/four pins
// - Select A bit 1 fixes CAN on P0.6/P0.7
// - Select A bit 0 fixes UART on P0.4/P0.5
// - Select B bit 7 routes timer one input
// - Select B bit 6 routes timer zero input
// - Select B bit 5 routes counter clock input
// - Bits 4:2 route lines 0..n-1; 111 reserved
// - Select B bit 1 outputs inverted system clock
// - Crossbar disabled keeps all pins inputs
// - UART and CAN pairs always take both pins; two-wire can get only SDA
// - GPIO pins are all pins not owned by a peripheral, skipped pins included
`timescale 1ns/100ps
module xbs_crossbar_sel #(
	parameter int NPINS = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_page,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic crossbar_global_enable,
	input wire logic [NPINS-1:0] pin_skip,
	input wire logic spi_nss_used,
	input wire logic [xbs_pkg::NSIG-1:0] sig_out,
	input wire logic [xbs_pkg::NSIG-1:0] sig_oe,
	output logic [xbs_pkg::NSIG-1:0] sig_in,
	input wire logic uart_tx,
	output logic uart_rx,
	input wire logic can_tx,
	output logic can_rx,
	input wire logic [NPINS-1:0] gpio_out,
	input wire logic [NPINS-1:0] gpio_oe,
	output logic [NPINS-1:0] gpio_in,
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe,
	output logic [NPINS-1:0] pin_is_periph
);
	localparam int IW = xbs_pkg::SIG_IW;
	logic [7:0] sel_a_r;
	logic [7:0] sel_b_r;
	logic [NPINS-1:0] pin_meta_r;
	logic [NPINS-1:0] pin_sync_r;
	logic [xbs_pkg::NSIG-1:0] req;
	logic [NPINS-1:0] fixed_claim;
	logic [NPINS-1:0] blocked;
	logic [NPINS*IW-1:0] dec_sel;
	logic [NPINS-1:0] dec_hit;
	logic [NPINS*IW-1:0] map_sel_r;
	logic [NPINS-1:0] map_hit_r;
	logic [NPINS-1:0] fixed_r;
	logic [2:0] lines;
	logic sysclk_inv;
	logic sfr_hit_a;
	logic sfr_hit_b;

	function automatic logic is_twowire(input int s);
		return s == xbs_pkg::S_TW_SDA || s == xbs_pkg::S_TW_SCL;
	endfunction : is_twowire

	assign sfr_hit_a = sfr_page == xbs_pkg::SFR_PAGE && sfr_addr == xbs_pkg::SELA_ADDR;
	assign sfr_hit_b = sfr_page == xbs_pkg::SFR_PAGE && sfr_addr == xbs_pkg::SELB_ADDR;

	// Select register A
	always_ff @(posedge clk)
	begin
		if (rst)
			sel_a_r <= xbs_pkg::SELA_RESET;
		else if (sfr_wr && sfr_hit_a)
			sel_a_r <= sfr_wdata;
	end

	// Select register B; bit 0 is stored as written
	always_ff @(posedge clk)
	begin
		if (rst)
			sel_b_r <= xbs_pkg::SELB_RESET;
		else if (sfr_wr && sfr_hit_b)
			sel_b_r <= sfr_wdata;
	end

	always_comb
	begin
		if (sfr_hit_a)
			sfr_rdata = sel_a_r;
		else if (sfr_hit_b)
			sfr_rdata = sel_b_r;
		else
			sfr_rdata = 8'h00;
	end

	// Pin inputs pass two flops before any use
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end
		else
		begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	assign lines = sel_b_r[xbs_pkg::B_LINES_HI:xbs_pkg::B_LINES_LO];

	always_comb
	begin
		req = '0;
		req[xbs_pkg::S_SPI_SCK] = sel_a_r[xbs_pkg::A_SPI];
		req[xbs_pkg::S_SPI_MISO] = sel_a_r[xbs_pkg::A_SPI];
		req[xbs_pkg::S_SPI_MOSI] = sel_a_r[xbs_pkg::A_SPI];
		req[xbs_pkg::S_SPI_NSS] = sel_a_r[xbs_pkg::A_SPI] & spi_nss_used;
		req[xbs_pkg::S_TW_SDA] = sel_a_r[xbs_pkg::A_TWOWIRE];
		req[xbs_pkg::S_TW_SCL] = sel_a_r[xbs_pkg::A_TWOWIRE];
		req[xbs_pkg::S_CMP0] = sel_a_r[xbs_pkg::A_CMP0];
		req[xbs_pkg::S_CMP0_ASYNC] = sel_a_r[xbs_pkg::A_CMP0_ASYNC];
		req[xbs_pkg::S_CMP1] = sel_a_r[xbs_pkg::A_CMP1];
		req[xbs_pkg::S_CMP1_ASYNC] = sel_a_r[xbs_pkg::A_CMP1_ASYNC];
		req[xbs_pkg::S_SYSCLK] = sel_b_r[xbs_pkg::B_SYSCLK];
		for (int k = 0; k < xbs_pkg::NLINES; k++)
			req[xbs_pkg::S_LINE0 + k] = lines != xbs_pkg::LINES_RSVD && k < int'(lines);
		req[xbs_pkg::S_ECI] = sel_b_r[xbs_pkg::B_ECI];
		req[xbs_pkg::S_TIMER0] = sel_b_r[xbs_pkg::B_TIMER0];
		req[xbs_pkg::S_TIMER1] = sel_b_r[xbs_pkg::B_TIMER1];
	end

	always_comb
	begin
		fixed_claim = '0;
		fixed_claim[xbs_pkg::PIN_UART_TX] = sel_a_r[xbs_pkg::A_UART];
		fixed_claim[xbs_pkg::PIN_UART_RX] = sel_a_r[xbs_pkg::A_UART];
		fixed_claim[xbs_pkg::PIN_CAN_TX] = sel_a_r[xbs_pkg::A_CAN];
		fixed_claim[xbs_pkg::PIN_CAN_RX] = sel_a_r[xbs_pkg::A_CAN];
	end

	assign blocked = pin_skip | fixed_claim;

	xbs_prio_dec #(
		.NSIG(xbs_pkg::NSIG),
		.NPINS(NPINS),
		.IW(IW)
	) u_dec (
		.req(req),
		.blocked(blocked),
		.pin_sel(dec_sel),
		.pin_hit(dec_hit)
	);

	// Assignment is registered; with crossbar off nothing is assigned
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			map_sel_r <= '0;
			map_hit_r <= '0;
			fixed_r <= '0;
		end
		else
		begin
			map_sel_r <= dec_sel;
			map_hit_r <= crossbar_global_enable ? (dec_hit | fixed_claim) : '0;
			// Fixed claims move with the map so a pin never mixes old and new owners
			fixed_r <= crossbar_global_enable ? fixed_claim : '0;
		end
	end

	assign pin_is_periph = map_hit_r;
	assign sysclk_inv = ~clk;

	// Pin drive: peripheral mux, else the pin's own GPIO bit; all off when disabled
	always_comb
	begin
		logic [IW-1:0] s;
		s = '0;
		pin_out = '0;
		pin_oe = '0;
		for (int p = 0; p < NPINS; p++)
		begin
			s = map_sel_r[p*IW +: IW];
			if (!crossbar_global_enable)
			begin
				pin_out[p] = 1'b0;
				pin_oe[p] = 1'b0;
			end
			else if (map_hit_r[p] && fixed_r[p])
			begin
				pin_out[p] = (p == xbs_pkg::PIN_UART_TX) ? uart_tx : can_tx;
				pin_oe[p] = (p == xbs_pkg::PIN_UART_TX || p == xbs_pkg::PIN_CAN_TX);
			end
			else if (map_hit_r[p])
			begin
				if (int'(s) == xbs_pkg::S_SYSCLK)
				begin
					pin_out[p] = sysclk_inv;
					pin_oe[p] = 1'b1;
				end
				else if (is_twowire(int'(s)))
				begin
					// Two-wire lines are open-drain: drive low only
					pin_out[p] = 1'b0;
					pin_oe[p] = sig_oe[s] & ~sig_out[s];
				end
				else
				begin
					pin_out[p] = sig_out[s];
					pin_oe[p] = sig_oe[s];
				end
			end
			else
			begin
				pin_out[p] = gpio_out[p];
				pin_oe[p] = gpio_oe[p];
			end
		end
	end

	// Inputs back to peripherals from their assigned pins
	always_comb
	begin
		sig_in = '0;
		uart_rx = 1'b1;
		can_rx = 1'b1;
		gpio_in = pin_sync_r;
		for (int p = 0; p < NPINS; p++)
		begin
			if (map_hit_r[p] && !fixed_r[p])
				sig_in[map_sel_r[p*IW +: IW]] = pin_sync_r[p];
		end
		if (map_hit_r[xbs_pkg::PIN_UART_RX] && fixed_r[xbs_pkg::PIN_UART_RX])
			uart_rx = pin_sync_r[xbs_pkg::PIN_UART_RX];
		if (map_hit_r[xbs_pkg::PIN_CAN_RX] && fixed_r[xbs_pkg::PIN_CAN_RX])
			can_rx = pin_sync_r[xbs_pkg::PIN_CAN_RX];
	end
endmodule : xbs_crossbar_sel

//--- dv/xbs_crossbar_sel_chk.sv
// Checker: port-level properties of the crossbar peripheral select
`timescale 1ns/100ps
module xbs_crossbar_sel_chk #(
	parameter int NPINS = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_page,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic crossbar_global_enable,
	input wire logic uart_tx,
	input wire logic can_tx,
	input wire logic [NPINS-1:0] gpio_oe,
	input wire logic [NPINS-1:0] gpio_in,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPINS-1:0] pin_out,
	input wire logic [NPINS-1:0] pin_oe,
	input wire logic [NPINS-1:0] pin_is_periph
);
	logic wr_a;
	logic rd_a;
	logic en;
	assign rd_a = sfr_page == 8'h0f && sfr_addr == 8'he1;
	assign wr_a = sfr_wr && rd_a;
	assign en = crossbar_global_enable;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_off_no_drive: assert property (!en |-> pin_oe == '0)
		else $error("pin driven while crossbar off");
	a_off_clears_map: assert property (!en |=> pin_is_periph == '0)
		else $error("map kept while crossbar off");
	a_sel_readback: assert property (wr_a |=> !rd_a || sfr_rdata == $past(sfr_wdata))
		else $error("select register readback wrong");
	a_unmapped_zero: assert property (!(sfr_page == 8'h0f && (sfr_addr == 8'he1 ||
		sfr_addr == 8'he2)) |-> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_uart_fixed_pins: assert property (wr_a && sfr_wdata[0] ##1 en [*2] |->
		pin_is_periph[5:4] == 2'b11 && pin_out[4] == uart_tx)
		else $error("uart pins not fixed");
	a_can_fixed_pins: assert property (wr_a && sfr_wdata[1] ##1 en [*2] |->
		pin_is_periph[7:6] == 2'b11 && pin_out[6] == can_tx)
		else $error("can pins not fixed");
	a_gpio_in_sync: assert property (!$past(rst) && !$past(rst, 2) |->
		gpio_in == $past(pin_in, 2))
		else $error("gpio input delay wrong");
	a_gpio_passthru: assert property (en && pin_is_periph == '0 |-> pin_oe == gpio_oe)
		else $error("free pin not general purpose");
	c_uart: cover property (wr_a && sfr_wdata[0]);
	c_owned: cover property (en && pin_is_periph[0]);
	c_off: cover property (!en && $past(en));
endmodule : xbs_crossbar_sel_chk

bind xbs_crossbar_sel xbs_crossbar_sel_chk #(.NPINS(NPINS)) u_chk (.clk(clk), .rst(rst),
	.sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .crossbar_global_enable(crossbar_global_enable),
	.uart_tx(uart_tx), .can_tx(can_tx), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_is_periph(pin_is_periph));

//--- dv/xbs_crossbar_sel_tb.sv
// Testbench: registers, enable gating, fixed pins and priority of the crossbar select
`timescale 1ns/100ps
module xbs_crossbar_sel_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_page = 8'h0f;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic en = 1'b0;
	logic [7:0] skip = 8'h00;
	logic nss = 1'b0;
	logic [xbs_pkg::NSIG-1:0] sig_out = 20'h00002;
	logic [xbs_pkg::NSIG-1:0] sig_in;
	logic uart_tx = 1'b0;
	logic uart_rx;
	logic can_tx = 1'b1;
	logic can_rx;
	logic [7:0] gpio_in;
	logic [7:0] pin_in = 8'hff;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pio;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	// Columns: select a, select b, slave-select used, expected owned pins
	logic [31:0] tbl [21] = '{32'h80000001, 32'h40000001, 32'h20000001, 32'h10000001,
		32'h08000003, 32'h0400010f, 32'h04000007, 32'h020000c0, 32'h01000030,
		32'h00800001, 32'h00400001, 32'h00200001, 32'h00020001, 32'h00040001,
		32'h00080003, 32'h000c0007, 32'h0010000f, 32'h0014001f, 32'h0018003f,
		32'h0c00001f, 32'hf000000f};

	xbs_crossbar_sel DUT (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.crossbar_global_enable(en), .pin_skip(skip), .spi_nss_used(nss),
		.sig_out(sig_out), .sig_oe(20'hfffff), .sig_in(sig_in), .uart_tx(uart_tx),
		.uart_rx(uart_rx), .can_tx(can_tx), .can_rx(can_rx), .gpio_out(8'h5a),
		.gpio_oe(8'hff), .gpio_in(gpio_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_is_periph(pio));

	always #20 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			miscompares++;
			conclude();
		end
	end

	task chk(input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
			$display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
		if (got !== exp)
			miscompares++;
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		sfr_addr = a;
		@(negedge clk);
		chk(exp, sfr_rdata);
	endtask : rd

	task t_regs;
		rd(8'he1, 8'h00);
		rd(8'he2, 8'h00);
		rd(8'he3, 8'h00);
		sfr_page = 8'h00;
		wr(8'he1, 8'hff);
		rd(8'he1, 8'h00);
		sfr_page = 8'h0f;
		rd(8'he1, 8'h00);
		$display("test regs done");
	endtask : t_regs

	task t_fixed;
		wr(8'he1, 8'h03);
		repeat (2) @(negedge clk);
		chk(8'h00, pin_oe);
		chk(8'h00, pio);
		en = 1'b1;
		uart_tx = 1'b1;
		can_tx = 1'b0;
		pin_in = 8'h7f;
		repeat (3) @(negedge clk);
		chk(8'hf0, pio);
		chk(8'h10, pin_out & 8'h50);
		chk(8'h02, {6'h00, uart_rx, can_rx});
		wr(8'he1, 8'h00);
		repeat (3) @(negedge clk);
		chk(8'h03, {6'h00, uart_rx, can_rx});
		$display("test fixed pins done");
	endtask : t_fixed

	task t_table;
		foreach (tbl[i])
		begin
			nss = tbl[i][8];
			wr(8'he1, tbl[i][31:24]);
			wr(8'he2, tbl[i][23:16]);
			repeat (2) @(negedge clk);
			chk(tbl[i][7:0], pio);
			rd(8'he1, tbl[i][31:24]);
			rd(8'he2, tbl[i][23:16]);
		end
		$display("test select table done");
	endtask : t_table

	task t_prio;
		skip = 8'h26;
		nss = 1'b1;
		pin_in = 8'h08;
		wr(8'he1, 8'h06);
		wr(8'he2, 8'h0c);
		repeat (3) @(negedge clk);
		chk(8'hd9, pio);
		chk(8'h08, pin_out & 8'h19);
		chk(8'h02, {5'h00, sig_in[2:0]});
		chk(8'h26, pin_oe & 8'h26);
		en = 1'b0;
		repeat (2) @(negedge clk);
		chk(8'h00, pio);
		$display("test priority done");
	endtask : t_prio

	task t_twowire_clk;
		skip = 8'h00;
		nss = 1'b0;
		en = 1'b1;
		wr(8'he1, 8'h08);
		wr(8'he2, 8'h02);
		repeat (2) @(negedge clk);
		chk(8'h07, pio);
		chk(8'h07, pin_oe & 8'h07);
		chk(8'h04, pin_out & 8'h07);
		@(posedge clk);
		#5;
		chk(8'h00, pin_out & 8'h04);
		@(negedge clk);
		sig_out = 20'h00012;
		#5;
		chk(8'h06, pin_oe & 8'h07);
		$display("test two-wire and clock done");
	endtask : t_twowire_clk

	task conclude;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_fixed();
		t_table();
		t_prio();
		t_twowire_clk();
		conclude();
	end
endmodule : xbs_crossbar_sel_tb
